// ---- verilog/dssp_port.sv ----
// Synchronous serial host port of a character display: link side and system side
//
// Summary of operation
// - Everything on the link moves in eight-bit units.
// - A cycle is exactly two bytes, a control byte then one instruction or data byte.
// - Each byte travels most significant bit first.
// - A direction bit of one makes a read, zero makes a write.
// - A select bit of zero marks an instruction, one marks display data.
// - In a write both bytes are captured on rising serial clock edges.
// - In a read the control byte is captured on rising serial clock edges too.
// - In a read the returned byte is driven out after each falling serial clock edge.
// - A cycle starts when the strobe falls and finishes when it rises.
// - The link is a strobe, a serial clock and one shared two-way data line.
`timescale 1ns/1ps

module dssp_port #(
  parameter int unsigned FIFO_DEPTH = dssp_pkg::FIFO_DEPTH
) (
  // System clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Serial link
  input  wire logic       serial_clk_i,
  input  wire logic       cycle_strobe_i,
  input  wire logic       sio_i,
  output logic            sio_o,
  output logic            sio_oe_o,
  // Received writes
  output logic            wr_valid_o,
  input  wire logic       wr_ready_i,
  output logic            wr_instr_data_select_bit_o,
  output logic [7:0]      wr_data_o,
  // Read answer source
  input  wire logic [7:0] rd_instr_i,
  input  wire logic [7:0] rd_data_i,
  output logic            rd_done_o,
  output logic            rd_instr_data_select_bit_o,
  // Status
  output logic            frame_active_o,
  output logic            rx_stall_o,
  output logic            overrun_o
);

  // ***************************************************************
  // Link domain: capture on rising serial clock
  // ***************************************************************
  logic [4:0]  bit_cnt_r;
  logic [4:0]  bit_cnt_nxt;
  logic [15:0] shift_r;
  logic [15:0] shift_nxt;
  logic [15:0] word_r;
  logic [15:0] word_nxt;
  logic        word_tgl_r;
  logic        word_tgl_nxt;
  logic        rd_act_r;
  logic        rd_act_nxt;
  logic [7:0]  rd_byte_r;
  logic [7:0]  rd_byte_nxt;
  logic [7:0]  ctrl_now;
  logic [7:0]  shadow_instr_r;
  logic [7:0]  shadow_instr_nxt;
  logic [7:0]  shadow_data_r;
  logic [7:0]  shadow_data_nxt;

  // Control byte check, used by both domains
  function automatic logic ctrl_ok(input logic [7:0] ctrl);
    ctrl_ok = (ctrl[dssp_pkg::SYNC_MSB:dssp_pkg::SYNC_LSB] == dssp_pkg::SYNC_PAT)
            && (ctrl[dssp_pkg::TAIL_BIT] == 1'b0);
  endfunction

  // Control byte as it stands once its last bit lands
  assign ctrl_now = {shift_r[6:0], sio_i};

  // Shift in MSB first, one bit per rising edge
  always_comb
  begin
    shift_nxt    = {shift_r[14:0], sio_i};
    bit_cnt_nxt  = bit_cnt_r;
    word_nxt     = word_r;
    word_tgl_nxt = word_tgl_r;
    rd_act_nxt   = rd_act_r;
    rd_byte_nxt  = rd_byte_r;
    if (bit_cnt_r != dssp_pkg::CNT_FULL)
      bit_cnt_nxt = bit_cnt_r + dssp_pkg::CNT_ONE;
    if (bit_cnt_r == dssp_pkg::CNT_CTRL)
    begin
      // Shadow bytes are frozen while the strobe is low, so they are stable here
      rd_act_nxt  = ctrl_ok(ctrl_now) && (ctrl_now[dssp_pkg::DIR_BIT] == dssp_pkg::DIR_READ);
      rd_byte_nxt = (ctrl_now[dssp_pkg::SEL_BIT] == dssp_pkg::SEL_DATA) ?
                    shadow_data_r : shadow_instr_r;
    end
    if (bit_cnt_r == dssp_pkg::CNT_LAST)
    begin
      word_nxt     = shift_nxt;
      word_tgl_nxt = 1'b1; // Level flag, cleared with the count when the strobe rises
    end
  end

  // The strobe ends the frame, since the serial clock may stop once it rises
  always_ff @(posedge serial_clk_i or posedge cycle_strobe_i)
  begin
    if (cycle_strobe_i)
    begin
      bit_cnt_r  <= dssp_pkg::CNT_ZERO;
      rd_act_r   <= 1'b0;
      word_tgl_r <= 1'b0; // A free-running toggle would never leave its unknown start
    end
    else
    begin
      bit_cnt_r  <= bit_cnt_nxt;
      rd_act_r   <= rd_act_nxt;
      word_tgl_r <= word_tgl_nxt;
    end
  end

  // Data registers hold across frames; the word toggle flag carries the event out
  always_ff @(posedge serial_clk_i)
  begin
    shift_r    <= shift_nxt;
    word_r     <= word_nxt;
    rd_byte_r  <= rd_byte_nxt;
  end

  // ***************************************************************
  // Link domain: drive out on falling serial clock
  // ***************************************************************
  logic [7:0] tx_r;
  logic [7:0] tx_nxt;
  logic       oe_r;
  logic       oe_nxt;

  // First fall after the control byte loads the byte, later falls shift it
  always_comb
  begin
    tx_nxt = tx_r;
    oe_nxt = oe_r;
    if (rd_act_r && (bit_cnt_r >= dssp_pkg::CNT_PAYLOAD))
    begin
      if (!oe_r)
      begin
        tx_nxt = rd_byte_r;
        oe_nxt = 1'b1;
      end
      else
        tx_nxt = {tx_r[6:0], 1'b0};
    end
  end

  // Line is released the moment the strobe rises
  always_ff @(negedge serial_clk_i or posedge cycle_strobe_i)
  begin
    if (cycle_strobe_i)
    begin
      tx_r <= 8'h00;
      oe_r <= 1'b0;
    end
    else
    begin
      tx_r <= tx_nxt;
      oe_r <= oe_nxt;
    end
  end

  assign sio_o    = tx_r[7];
  assign sio_oe_o = oe_r;

  // ***************************************************************
  // System domain: crossings
  // ***************************************************************
  logic [1:0] link_s;
  logic       strobe_s;
  logic       tgl_s;

  // Strobe level and word toggle share the same latency, keeping their order
  dssp_sync2 #(
    .WIDTH (2)
  ) u_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .async_i ({cycle_strobe_i, word_tgl_r}),
    .sync_o  (link_s)
  );

  assign strobe_s = link_s[1];
  assign tgl_s    = link_s[0];

  // ***************************************************************
  // System domain: frame acceptance
  // ***************************************************************
  logic        strobe_q_r;
  logic        strobe_q_nxt;
  logic        tgl_q_r;
  logic        tgl_q_nxt;
  logic        pend_r;
  logic        pend_nxt;
  logic [15:0] pend_word_r;
  logic [15:0] pend_word_nxt;
  logic        push_r;
  logic        push_nxt;
  logic [8:0]  push_data_r;
  logic [8:0]  push_data_nxt;
  logic        rd_done_r;
  logic        rd_done_nxt;
  logic        rd_sel_r;
  logic        rd_sel_nxt;
  logic        overrun_r;
  logic        overrun_nxt;
  logic        fifo_in_ready;
  logic [8:0]  fifo_out_data;
  logic [7:0]  pend_ctrl;
  logic        strobe_rise;

  assign pend_ctrl   = pend_word_r[15:8];
  assign strobe_rise = strobe_s & ~strobe_q_r;

  // Word is stable in the link register once its toggle is seen here
  always_comb
  begin
    strobe_q_nxt     = strobe_s;
    tgl_q_nxt        = tgl_s;
    pend_nxt         = pend_r;
    pend_word_nxt    = pend_word_r;
    push_nxt         = push_r;
    push_data_nxt    = push_data_r;
    rd_done_nxt      = 1'b0;
    rd_sel_nxt       = rd_sel_r;
    overrun_nxt      = 1'b0;
    shadow_instr_nxt = shadow_instr_r;
    shadow_data_nxt  = shadow_data_r;
    // Shadow follows the user only between frames
    if (strobe_s)
    begin
      shadow_instr_nxt = rd_instr_i;
      shadow_data_nxt  = rd_data_i;
    end
    if (push_r && fifo_in_ready)
      push_nxt = 1'b0;
    // A frame that never reached sixteen bits leaves nothing pending
    if (tgl_s && !tgl_q_r)
    begin
      pend_nxt      = 1'b1;
      pend_word_nxt = word_r;
    end
    if (strobe_rise && pend_r)
    begin
      pend_nxt = 1'b0;
      if (ctrl_ok(pend_ctrl))
      begin
        if (pend_ctrl[dssp_pkg::DIR_BIT] == dssp_pkg::DIR_READ)
        begin
          rd_done_nxt = 1'b1;
          rd_sel_nxt  = pend_ctrl[dssp_pkg::SEL_BIT];
        end
        else if (push_r && !fifo_in_ready)
          overrun_nxt = 1'b1; // Hold slot busy: newest write lost
        else
        begin
          push_nxt      = 1'b1;
          push_data_nxt = {pend_ctrl[dssp_pkg::SEL_BIT], pend_word_r[7:0]};
        end
      end
    end
  end

  // Registered acceptance state
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      strobe_q_r     <= 1'b1;
      tgl_q_r        <= 1'b0;
      pend_r         <= 1'b0;
      pend_word_r    <= 16'h0000;
      push_r         <= 1'b0;
      push_data_r    <= 9'h000;
      rd_done_r      <= 1'b0;
      rd_sel_r       <= 1'b0;
      overrun_r      <= 1'b0;
      shadow_instr_r <= 8'h00;
      shadow_data_r  <= 8'h00;
    end
    else
    begin
      strobe_q_r     <= strobe_q_nxt;
      tgl_q_r        <= tgl_q_nxt;
      pend_r         <= pend_nxt;
      pend_word_r    <= pend_word_nxt;
      push_r         <= push_nxt;
      push_data_r    <= push_data_nxt;
      rd_done_r      <= rd_done_nxt;
      rd_sel_r       <= rd_sel_nxt;
      overrun_r      <= overrun_nxt;
      shadow_instr_r <= shadow_instr_nxt;
      shadow_data_r  <= shadow_data_nxt;
    end
  end

  // ***************************************************************
  // Write buffer
  // ***************************************************************
  dssp_fifo #(
    .WIDTH (dssp_pkg::FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .in_valid_i  (push_r),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (push_data_r),
    .out_valid_o (wr_valid_o),
    .out_ready_i (wr_ready_i),
    .out_data_o  (fifo_out_data)
  );

  // User side outputs
  assign wr_instr_data_select_bit_o = fifo_out_data[8];
  assign wr_data_o                  = fifo_out_data[7:0];
  assign rd_done_o                  = rd_done_r;
  assign rd_instr_data_select_bit_o = rd_sel_r;
  assign frame_active_o             = ~strobe_q_r;
  assign rx_stall_o                 = push_r & ~fifo_in_ready; // Full buffer stalls the slot
  assign overrun_o                  = overrun_r;

endmodule

// ---- verilog/dssp_pkg.sv ----
// Constants shared by the display synchronous serial port blocks
package dssp_pkg;

  // ***************************************************************
  // Frame layout
  // ***************************************************************
  localparam int unsigned BYTE_W      = 8;    // Bits in one serial unit
  localparam int unsigned FRAME_BITS  = 16;   // Control byte plus one payload byte
  localparam int unsigned CNT_W       = 5;    // Wide enough to count past a frame
  localparam logic [4:0]  CNT_CTRL    = 5'h07; // Count seen while last control bit lands
  localparam logic [4:0]  CNT_PAYLOAD = 5'h08; // Count once the control byte is in
  localparam logic [4:0]  CNT_LAST    = 5'h0F; // Count seen while last payload bit lands
  localparam logic [4:0]  CNT_FULL    = 5'h10; // Count once both bytes are in
  localparam logic [4:0]  CNT_ONE     = 5'h01;
  localparam logic [4:0]  CNT_ZERO    = 5'h00;

  // ***************************************************************
  // Control byte fields
  // ***************************************************************
  localparam int unsigned SYNC_MSB    = 7;
  localparam int unsigned SYNC_LSB    = 3;
  localparam logic [4:0]  SYNC_PAT    = 5'h1F;   // Five leading ones
  localparam int unsigned DIR_BIT     = 2;       // One reads, zero writes
  localparam int unsigned SEL_BIT     = 1;       // Zero instruction, one data
  localparam int unsigned TAIL_BIT    = 0;       // Must be zero
  localparam logic        DIR_READ    = 1'b1;
  localparam logic        SEL_DATA    = 1'b1;

  // ***************************************************************
  // Buffering
  // ***************************************************************
  localparam int unsigned FIFO_DEPTH  = 16;
  localparam int unsigned FIFO_WIDTH  = 9;  // Select bit above the payload byte

endpackage

// ---- verilog/dssp_sync2.sv ----
// Two flip-flop level synchroniser
`timescale 1ns/1ps

module dssp_sync2 #(
  parameter int unsigned WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // Levels
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] meta_nxt;
  logic [WIDTH-1:0] sync_r;
  logic [WIDTH-1:0] sync_nxt;

  // First stage feeds the second stage only
  always_comb
  begin
    meta_nxt = async_i;
    sync_nxt = meta_r;
  end

  // Both stages clear to zero under reset
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      meta_r <= '0;
      sync_r <= '0;
    end
    else
    begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign sync_o = sync_r;

endmodule

// ---- verilog/dssp_fifo.sv ----
// Synchronous FIFO with valid and ready on both sides
`timescale 1ns/1ps

module dssp_fifo #(
  parameter int unsigned WIDTH = 9,
  parameter int unsigned DEPTH = 16
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // Fill side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);

  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    wr_ptr_nxt;
  logic [AW-1:0]    rd_ptr_r;
  logic [AW-1:0]    rd_ptr_nxt;
  logic [AW:0]      count_r;
  logic [AW:0]      count_nxt;
  logic             push;
  logic             pop;

  // Full and empty come straight from the occupancy count
  assign in_ready_o  = (count_r != DEPTH[AW:0]);
  assign out_valid_o = (count_r != '0);
  assign out_data_o  = mem_r[rd_ptr_r];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  // Pointer wrap handles depths that are not a power of two
  always_comb
  begin
    wr_ptr_nxt = wr_ptr_r;
    rd_ptr_nxt = rd_ptr_r;
    count_nxt  = count_r;
    if (push)
      wr_ptr_nxt = (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + AW'(1);
    if (pop)
      rd_ptr_nxt = (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + AW'(1);
    if (push && !pop)
      count_nxt = count_r + (AW+1)'(1);
    else if (pop && !push)
      count_nxt = count_r - (AW+1)'(1);
  end

  // Storage needs no reset; only pointers and count are control state
  always_ff @(posedge clk_i)
  begin
    if (push)
      mem_r[wr_ptr_r] <= in_data_i;
    if (rst_i)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end
    else
    begin
      wr_ptr_r <= wr_ptr_nxt;
      rd_ptr_r <= rd_ptr_nxt;
      count_r  <= count_nxt;
    end
  end

endmodule

// ---- tb/dssp_port_chk.sv ----
// Boundary checker for the display serial port
`timescale 1ns/1ps

module dssp_port_chk (
  // Clocks and reset
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       serial_clk_i,
  // Link
  input wire logic       cycle_strobe_i,
  input wire logic       sio_i,
  input wire logic       sio_oe_o,
  // System side
  input wire logic       wr_valid_o,
  input wire logic       wr_ready_i,
  input wire logic       wr_instr_data_select_bit_o,
  input wire logic [7:0] wr_data_o,
  input wire logic       rd_done_o,
  input wire logic       frame_active_o,
  input wire logic       rx_stall_o,
  input wire logic       overrun_o
);
  // ***************************************************************
  // Link side
  // ***************************************************************
  logic [4:0] rise_cnt_r;
  logic [4:0] rise_cnt_nxt;

  // Saturate so a long frame cannot wrap back into the read window
  always_comb
    rise_cnt_nxt = (rise_cnt_r == 5'h1F) ? rise_cnt_r : rise_cnt_r + 5'h01;

  // Rising serial edges seen in this frame; strobe high clears
  always_ff @(posedge serial_clk_i or posedge cycle_strobe_i)
    if (cycle_strobe_i)
      rise_cnt_r <= 5'h00;
    else
      rise_cnt_r <= rise_cnt_nxt;

  // Read control byte: five ones, direction one, any select, zero
  sequence s_read_ctl;
    (rise_cnt_r == 5'h00 && sio_i) ##1 sio_i [*5] ##1 1'b1 ##1 !sio_i;
  endsequence
  property p_oe_read;
    @(posedge serial_clk_i) disable iff (cycle_strobe_i) s_read_ctl |=> sio_oe_o;
  endproperty
  a_oe_read: assert property (p_oe_read) else $error("read not driven");
  property p_oe_late;
    @(posedge serial_clk_i) disable iff (cycle_strobe_i) sio_oe_o |-> rise_cnt_r >= 5'h08;
  endproperty
  a_oe_late: assert property (p_oe_late) else $error("drive too early");

  // ***************************************************************
  // System side
  // ***************************************************************
  sequence s_frame_held;
    !cycle_strobe_i [*5];
  endsequence
  property p_active_seen;
    @(posedge clk_i) disable iff (rst_i) s_frame_held |-> frame_active_o;
  endproperty
  a_active_seen: assert property (p_active_seen) else $error("frame flag late");
  property p_oe_idle;
    @(posedge clk_i) disable iff (rst_i) cycle_strobe_i |-> !sio_oe_o;
  endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("drive outside frame");
  property p_done_pulse;
    @(posedge clk_i) disable iff (rst_i) rd_done_o |=> !rd_done_o;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done too long");
  property p_done_late;
    @(posedge clk_i) disable iff (rst_i)
      rd_done_o |-> !frame_active_o && $past(cycle_strobe_i, 2);
  endproperty
  a_done_late: assert property (p_done_late) else $error("done before end");
  property p_head_hold;
    @(posedge clk_i) disable iff (rst_i) wr_valid_o && !wr_ready_i |=> wr_valid_o
      && $stable(wr_data_o) && $stable(wr_instr_data_select_bit_o);
  endproperty
  a_head_hold: assert property (p_head_hold) else $error("head word moved");
  property p_ovr_cause;
    @(posedge clk_i) disable iff (rst_i) overrun_o |-> $past(rx_stall_o) ##1 !overrun_o;
  endproperty
  a_ovr_cause: assert property (p_ovr_cause) else $error("overrun unexpected");
  property p_stall_full;
    @(posedge clk_i) disable iff (rst_i) rx_stall_o |-> wr_valid_o;
  endproperty
  a_stall_full: assert property (p_stall_full) else $error("stall while empty");
endmodule

bind dssp_port dssp_port_chk chk_u (
  .clk_i                     (clk_i),
  .rst_i                     (rst_i),
  .serial_clk_i              (serial_clk_i),
  .cycle_strobe_i            (cycle_strobe_i),
  .sio_i                     (sio_i),
  .sio_oe_o                  (sio_oe_o),
  .wr_valid_o                (wr_valid_o),
  .wr_ready_i                (wr_ready_i),
  .wr_instr_data_select_bit_o(wr_instr_data_select_bit_o),
  .wr_data_o                 (wr_data_o),
  .rd_done_o                 (rd_done_o),
  .frame_active_o            (frame_active_o),
  .rx_stall_o                (rx_stall_o),
  .overrun_o                 (overrun_o)
);

// ---- tb/dssp_host_model.sv ----
// Host model driving strobe, serial clock and the shared data line
`timescale 1ns/1ps

module dssp_host_model (
  // Link outputs
  output logic      sclk_o,
  output logic      strobe_o,
  output logic      drv_o,
  output logic      bit_o,
  // Resolved line
  input  wire logic sio_i
);
  // Idle link: clock parked high, strobe high, line released
  initial
  begin
    sclk_o   = 1'b1;
    strobe_o = 1'b1;
    drv_o    = 1'b0;
    bit_o    = 1'b0;
  end

  // One cycle of n bits; the clock only moves inside the frame
  task automatic xfer(input logic [7:0] ctl, input logic [7:0] pay, input int n,
                      output logic [7:0] got);
    logic [15:0] sh;
    sh  = {ctl, pay};
    got = 8'h00;
    #3.3 strobe_o = 1'b0;
    #20;
    for (int i = 0; i < n; i++)
    begin
      if (i == 8 && ctl[2])
        #150;
      sclk_o = 1'b0;
      #2;
      drv_o = !(i >= 8 && ctl[2]);
      bit_o = sh[15 - i];
      #22 sclk_o = 1'b1;
      got = {got[6:0], sio_i};
      #24;
    end
    #10 strobe_o = 1'b1;
    drv_o = 1'b0;
    #100;
  endtask
endmodule

// ---- tb/dssp_port_tb.sv ----
// Self-checking bench for the display serial port
`timescale 1ns/1ps

module dssp_port_tb;
  logic       clk_i        = 1'b0;
  logic       rst_i        = 1'b1;
  logic       sclk;
  logic       strobe;
  logic       drv;
  logic       hbit;
  logic       sio_w;
  logic       sio_o;
  logic       sio_oe;
  logic       wr_valid;
  logic       wr_ready     = 1'b0;
  logic       wr_sel;
  logic [7:0] wr_data;
  logic [7:0] rd_instr     = 8'hC3;
  logic [7:0] rd_data      = 8'h3A;
  logic       rd_done;
  logic       rd_sel;
  logic       active;
  logic       stall;
  logic       ovr;
  int         bad_count    = 0;
  int         total_checks = 0;
  int         done_n       = 0;
  int         ovr_n        = 0;
  int         cyc          = 0;

  always #5 clk_i = ~clk_i;

  // Released line shows the inverse of the last host bit
  assign sio_w = sio_oe ? sio_o : (drv ? hbit : ~hbit);

  dssp_host_model host_u (
    .sclk_o  (sclk),
    .strobe_o(strobe),
    .drv_o   (drv),
    .bit_o   (hbit),
    .sio_i   (sio_w)
  );

  dssp_port dut_u (
    .clk_i                     (clk_i),
    .rst_i                     (rst_i),
    .serial_clk_i              (sclk),
    .cycle_strobe_i            (strobe),
    .sio_i                     (sio_w),
    .sio_o                     (sio_o),
    .sio_oe_o                  (sio_oe),
    .wr_valid_o                (wr_valid),
    .wr_ready_i                (wr_ready),
    .wr_instr_data_select_bit_o(wr_sel),
    .wr_data_o                 (wr_data),
    .rd_instr_i                (rd_instr),
    .rd_data_i                 (rd_data),
    .rd_done_o                 (rd_done),
    .rd_instr_data_select_bit_o(rd_sel),
    .frame_active_o            (active),
    .rx_stall_o                (stall),
    .overrun_o                 (ovr)
  );

  // Pulse counters and the hang limit
  always @(posedge clk_i)
  begin
    cyc++;
    if (rd_done === 1'b1)
      done_n++;
    if (ovr === 1'b1)
      ovr_n++;
    if (cyc == 20000)
    begin
      bad_count++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    if (bad_count == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [9:0] exp, input logic [9:0] got);
    total_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Wait for a head word, compare it, then pop it with one ready cycle
  task automatic pop_check(input logic s, input logic [7:0] d);
    int n;
    n = 0;
    while (wr_valid !== 1'b1 && n < 300)
    begin
      @(posedge clk_i);
      #1;
      n++;
    end
    chk("wr_word", {1'b1, s, d}, {wr_valid, wr_sel, wr_data});
    wr_ready = 1'b1;
    @(posedge clk_i);
    #1;
    wr_ready = 1'b0;
  endtask

  // Two writes back to back, instruction then data, with edge patterns
  task automatic t_write();
    logic [7:0] q;
    host_u.xfer(8'hF8, 8'h81, 16, q);
    host_u.xfer(8'hFA, 8'h7E, 16, q);
    pop_check(1'b0, 8'h81);
    pop_check(1'b1, 8'h7E);
  endtask

  // Reads of both kinds; the returned byte follows the select bit
  task automatic t_read();
    logic [7:0] q;
    int         d0;
    for (int s = 0; s < 2; s++)
    begin
      d0 = done_n;
      host_u.xfer({5'h1F, 1'b1, s[0], 1'b0}, 8'h00, 16, q);
      chk("rd_byte", {2'b00, s[0] ? 8'h3A : 8'hC3}, {2'b00, q});
      chk("rd_done", 10'(d0 + 1), 10'(done_n));
      chk("rd_sel", {9'h000, s[0]}, {9'h000, rd_sel});
    end
    chk("rd_no_write", 10'h000, {9'h000, wr_valid});
  endtask

  // Broken and short cycles leave nothing behind
  task automatic t_bad();
    logic [7:0] q;
    int         d0;
    d0 = done_n;
    host_u.xfer(8'h78, 8'h11, 16, q);
    host_u.xfer(8'hF9, 8'h22, 16, q);
    host_u.xfer(8'hFC, 8'h33, 12, q);
    host_u.xfer(8'hF8, 8'h44, 15, q);
    host_u.xfer(8'hF8, 8'h55, 16, q);
    pop_check(1'b0, 8'h55);
    chk("bad_done", 10'(d0), 10'(done_n));
  endtask

  // Fill the buffer and holding slot, overrun once, then drain in order
  task automatic t_fifo();
    logic [7:0] q;
    int         o0;
    o0 = ovr_n;
    for (int i = 0; i <= dssp_pkg::FIFO_DEPTH; i++)
      host_u.xfer(8'hF8, 8'(i), 16, q);
    chk("stall", 10'h001, {9'h000, stall});
    host_u.xfer(8'hFA, 8'hEE, 16, q);
    chk("overrun", 10'(o0 + 1), 10'(ovr_n));
    for (int i = 0; i <= dssp_pkg::FIFO_DEPTH; i++)
      pop_check(1'b0, 8'(i));
    chk("drained", 10'h000, {8'h00, stall, wr_valid});
  endtask

  // Main sequence
  initial
  begin
    repeat (10) @(posedge clk_i);
    #1;
    chk("rst_out", 10'h000, {5'h00, rd_done, ovr, stall, active, wr_valid});
    repeat (10) @(posedge clk_i);
    #1;
    rst_i = 1'b0;
    repeat (5) @(posedge clk_i);
    #1;
    t_write();
    t_read();
    t_bad();
    t_fifo();
    tally_and_finish();
  end
endmodule
